// ### design/ssp_top.sv
// synchronous slave serial port: apb registers, transmit and receive shifters on an external shift clock
`timescale 1ns/1ns
`default_nettype none

module ssp_top
	import ssp_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link pins
	input wire logic shift_clock_pin_in,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	// wake and interrupt request toward the core
	output logic wake_request
);
	import ssp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ssp_rx_status_t rx_ctl_r;
	ssp_tx_status_t tx_ctl_r;
	ssp_tx_state_t tx_state_r;
	logic [7:0] baud_ctl_r, div_hi_r, div_lo_r, hold_r, rcbuf_r;
	logic [8:0] tsr_r, rsr_r;
	logic [3:0] tx_cnt_r, rx_cnt_r;
	logic hold_full_r, dt_out_r, dt_oe_r, received_ninth_bit_r, rcif_r, overrun_error_flag_r;
	logic txie_r, rcie_r, wake_r;
	logic ck_q1_r, ck_q2_r, ck_q3_r, dt_q1_r, dt_q2_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;

	// ------------------------------------------------------------
	// mode and edge decode
	// ------------------------------------------------------------
	wire logic slave_mode = rx_ctl_r.serial_port_enable & tx_ctl_r.sync_mode_select
		& ~tx_ctl_r.clock_source_select;
	// the pin is half duplex: receive has the pin whenever continuous receive is on
	wire logic tx_on = slave_mode & tx_ctl_r.transmit_enable & ~rx_ctl_r.continuous_receive_enable;
	// single receive enable is deliberately absent here; an overrun stalls reception
	wire logic rx_on = slave_mode & rx_ctl_r.continuous_receive_enable & ~overrun_error_flag_r;
	// only the second and third stages are compared, never the first
	wire logic ck_fall = ck_q3_r & ~ck_q2_r;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire logic setup_c = psel & ~penable;
	wire logic wr_en = psel & penable & pready_r & pwrite;
	wire logic rd_en = psel & penable & pready_r & ~pwrite;
	wire logic hit_rxs = paddr == OFS_RX_STATUS;
	wire logic hit_txh = paddr == OFS_TX_HOLD;
	wire logic hit_txs = paddr == OFS_TX_STATUS;
	wire logic hit_bc = paddr == OFS_BAUD_CTRL;
	wire logic hit_dh = paddr == OFS_BAUD_DIV_HI;
	wire logic hit_dl = paddr == OFS_BAUD_DIV_LO;
	wire logic hit_rxb = paddr == OFS_RX_BUF;
	wire logic hit_ev = paddr == OFS_EVENT_CTRL;
	wire logic mapped = hit_rxs | hit_txh | hit_txs | hit_bc | hit_dh | hit_dl | hit_rxb | hit_ev;

	// ------------------------------------------------------------
	// transmit path decode
	// ------------------------------------------------------------
	wire logic tx_load = wr_en & hit_txh & tx_on;
	wire logic tx_xfer = hold_full_r & (tx_state_r == TX_IDLE) & tx_on;
	wire logic tx_empty = ~hold_full_r;
	wire logic [3:0] tx_bits = tx_ctl_r.nine_bit_transmit_select ? BITS_9 : BITS_8;
	// the held word stays until the shifter is idle again
	wire logic hold_full_nxt = tx_load | (hold_full_r & ~tx_xfer & tx_on);

	// ------------------------------------------------------------
	// receive path decode
	// ------------------------------------------------------------
	wire logic [3:0] rx_bits = rx_ctl_r.nine_bit_receive_select ? BITS_9 : BITS_8;
	wire logic [8:0] rx_word = {dt_q2_r, rsr_r[8:1]};
	wire logic rx_done = rx_on & ck_fall & (rx_cnt_r == rx_bits - 4'h1);
	wire logic rcbuf_read = rd_en & hit_rxb;
	// a buffer read in the completing cycle frees room for the new word
	wire logic rx_accept = rx_done & (~rcif_r | rcbuf_read);
	wire logic rcif_nxt = rx_accept | (rcif_r & ~rcbuf_read);
	wire logic overrun_error_flag_nxt = rx_ctl_r.continuous_receive_enable & (overrun_error_flag_r | (rx_done & ~rx_accept));

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------
	// framing errors cannot happen on a clocked link, so that bit reads zero
	wire logic [7:0] rxs_rd = {rx_ctl_r[7:3], 1'b0, overrun_error_flag_r, received_ninth_bit_r};
	wire logic [7:0] txs_rd = {tx_ctl_r[7:2], tx_state_r == TX_IDLE, tx_ctl_r.transmit_ninth_bit};
	wire logic [7:0] bc_rd = {baud_ctl_r[7], rx_cnt_r == 4'h0, baud_ctl_r[5:0]};
	wire logic [7:0] ev_rd = {4'h0, rcie_r, txie_r, rcif_r, tx_empty};
	wire logic [7:0] rd_byte = ({8{hit_rxs}} & rxs_rd) | ({8{hit_txs}} & txs_rd) | ({8{hit_bc}} & bc_rd)
		| ({8{hit_dh}} & div_hi_r) | ({8{hit_dl}} & div_lo_r) | ({8{hit_rxb}} & rcbuf_r)
		| ({8{hit_ev}} & ev_rd);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// the clock pin takes three stages and the data pin two, so data stays aligned with the clock edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ck_q1_r <= 1'b0;
			ck_q2_r <= 1'b0;
			ck_q3_r <= 1'b0;
			dt_q1_r <= 1'b0;
			dt_q2_r <= 1'b0;
		end
		else
		begin
			ck_q1_r <= shift_clock_pin_in;
			ck_q2_r <= ck_q1_r;
			ck_q3_r <= ck_q2_r;
			dt_q1_r <= serial_data_pin_in;
			dt_q2_r <= dt_q1_r;
		end
	end

	// ------------------------------------------------------------
	// apb answer: zero wait states, decoded at the setup edge
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= WORD_RST;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= setup_c ? {24'h000000, rd_byte} : WORD_RST;
			pready_r <= setup_c;
			pslverr_r <= setup_c & ~mapped;
		end
	end

	// ------------------------------------------------------------
	// software control registers
	// ------------------------------------------------------------
	// status bits inside these registers are read-only and skipped on write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_ctl_r <= REG8_RST;
			tx_ctl_r <= REG8_RST;
			baud_ctl_r <= REG8_RST;
			div_hi_r <= REG8_RST;
			div_lo_r <= REG8_RST;
			txie_r <= 1'b0;
			rcie_r <= 1'b0;
		end
		else
		begin
			if (wr_en && hit_rxs)
				rx_ctl_r[7:3] <= pwdata[7:3];
			if (wr_en && hit_txs)
				tx_ctl_r <= {pwdata[7:2], 1'b0, pwdata[0]};
			if (wr_en && hit_bc)
				baud_ctl_r <= pwdata[7:0];
			if (wr_en && hit_dh)
				div_hi_r <= pwdata[7:0];
			if (wr_en && hit_dl)
				div_lo_r <= pwdata[7:0];
			if (wr_en && hit_ev)
			begin
				txie_r <= pwdata[EV_TX_IE_BIT];
				rcie_r <= pwdata[EV_RX_IE_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// transmit holding register
	// ------------------------------------------------------------
	// a write over a full holding register replaces the waiting word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_r <= REG8_RST;
			hold_full_r <= 1'b0;
		end
		else
		begin
			if (tx_load)
				hold_r <= pwdata[7:0];
			hold_full_r <= hold_full_nxt;
		end
	end

	// ------------------------------------------------------------
	// transmit shifter: next bit goes out after each falling shift clock edge
	// ------------------------------------------------------------
	// the partner samples on the falling edge, so the pin changes just after it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state_r <= TX_IDLE;
			tsr_r <= 9'h000;
			tx_cnt_r <= 4'h0;
			dt_out_r <= 1'b0;
			dt_oe_r <= 1'b0;
		end
		else
		begin
			dt_oe_r <= tx_on;
			if (!tx_on)
			begin
				tx_state_r <= TX_IDLE;
				tx_cnt_r <= 4'h0;
			end
			else
			begin
				case (tx_state_r)
					TX_IDLE:
					begin
						if (tx_xfer)
						begin
							tsr_r <= {tx_ctl_r.transmit_ninth_bit, hold_r};
							tx_cnt_r <= tx_bits;
							dt_out_r <= hold_r[0];
							tx_state_r <= TX_SHIFT;
						end
					end
					TX_SHIFT:
					begin
						if (ck_fall)
						begin
							tsr_r <= {1'b0, tsr_r[8:1]};
							tx_cnt_r <= tx_cnt_r - 4'h1;
							dt_out_r <= tsr_r[1];
							if (tx_cnt_r == 4'h1)
								tx_state_r <= TX_IDLE;
						end
					end
					default:
						tx_state_r <= TX_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// receive shifter and buffer
	// ------------------------------------------------------------
	// the buffer is one word deep; a second word that finds it full is dropped as overrun
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rsr_r <= 9'h000;
			rx_cnt_r <= 4'h0;
			rcbuf_r <= REG8_RST;
			received_ninth_bit_r <= 1'b0;
			rcif_r <= 1'b0;
			overrun_error_flag_r <= 1'b0;
		end
		else
		begin
			if (!rx_on)
				rx_cnt_r <= 4'h0;
			else if (ck_fall)
			begin
				rsr_r <= rx_word;
				rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
			end
			if (rx_accept)
			begin
				rcbuf_r <= rx_ctl_r.nine_bit_receive_select ? rx_word[7:0] : rx_word[8:1];
				received_ninth_bit_r <= rx_ctl_r.nine_bit_receive_select & rx_word[8];
			end
			rcif_r <= rcif_nxt;
			overrun_error_flag_r <= overrun_error_flag_nxt;
		end
	end

	// ------------------------------------------------------------
	// wake request
	// ------------------------------------------------------------
	// one level covers sleep wake-up and the interrupt request alike
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_r <= 1'b0;
		else
			wake_r <= (tx_empty & txie_r) | (rcif_r & rcie_r);
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign serial_data_pin_out = dt_out_r;
	assign serial_data_pin_oe = dt_oe_r;
	assign wake_request = wake_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_pin_drive_mode;
		@(posedge pclk) disable iff (!presetn)
		dt_oe_r |-> $past(slave_mode) && !$past(tx_ctl_r.clock_source_select);
	endproperty
	a_pin_drive_mode: assert property (p_pin_drive_mode) else $error("data pin driven outside slave mode");
	property p_first_word;
		@(posedge pclk) disable iff (!presetn)
		(tx_load && !hold_full_r && tx_state_r == TX_IDLE) ##1 tx_on |=> tx_state_r == TX_SHIFT && tsr_r[7:0] == $past(hold_r);
	endproperty
	a_first_word: assert property (p_first_word) else $error("first word did not enter the shifter");
	property p_hold_waits;
		@(posedge pclk) disable iff (!presetn)
		(hold_full_r && tx_state_r == TX_SHIFT) |-> !tx_empty ##1 hold_full_r || !tx_on;
	endproperty
	a_hold_waits: assert property (p_hold_waits) else $error("held word lost while shifting");
	property p_xfer_sets_empty;
		@(posedge pclk) disable iff (!presetn)
		(tx_xfer && !tx_load) |=> tx_empty && tx_state_r == TX_SHIFT;
	endproperty
	a_xfer_sets_empty: assert property (p_xfer_sets_empty) else $error("empty flag not set after transfer");

	property p_tx_wake;
		@(posedge pclk) disable iff (!presetn)
		(tx_empty && txie_r) |=> wake_r;
	endproperty
	a_tx_wake: assert property (p_tx_wake) else $error("no wake on transmit empty");
	property p_single_ignored;
		@(posedge pclk) disable iff (!presetn)
		(slave_mode && rx_ctl_r.single_receive_enable && !rx_ctl_r.continuous_receive_enable) [*2] |-> rx_cnt_r == 4'h0;
	endproperty
	a_single_ignored: assert property (p_single_ignored) else $error("single receive started a reception");

	property p_rx_to_buffer;
		@(posedge pclk) disable iff (!presetn)
		(rx_done && !rcif_r) |=> rcif_r && rcbuf_r == (rx_ctl_r.nine_bit_receive_select ? $past(rx_word[7:0]) : $past(rx_word[8:1]));
	endproperty
	a_rx_to_buffer: assert property (p_rx_to_buffer) else $error("received word not moved to buffer");

	property p_rx_wake;
		@(posedge pclk) disable iff (!presetn)
		(rx_accept && rcie_r) |=> ##1 wake_r;
	endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("no wake on receive complete");

	property p_error_clear;
		@(posedge pclk) disable iff (!presetn)
		!rx_ctl_r.continuous_receive_enable |=> !overrun_error_flag_r;
	endproperty
	a_error_clear: assert property (p_error_clear) else $error("overrun kept with receive disabled");

	property p_sample_on_fall;
		@(posedge pclk) disable iff (!presetn)
		(rx_cnt_r != $past(rx_cnt_r) && rx_cnt_r != 4'h0) |-> $past(ck_fall);
	endproperty
	a_sample_on_fall: assert property (p_sample_on_fall) else $error("receive bit taken without falling edge");

endmodule

`default_nettype wire

// ### pkg/ssp_pkg.sv
// shared constants, register layouts and types of the synchronous slave serial port
package ssp_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the apb slave
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_RX_STATUS = 8'h00;
	localparam logic [7:0] OFS_TX_HOLD = 8'h04;
	localparam logic [7:0] OFS_TX_STATUS = 8'h08;
	localparam logic [7:0] OFS_BAUD_CTRL = 8'h0C;
	localparam logic [7:0] OFS_BAUD_DIV_HI = 8'h10;
	localparam logic [7:0] OFS_BAUD_DIV_LO = 8'h14;
	localparam logic [7:0] OFS_RX_BUF = 8'h18;
	localparam logic [7:0] OFS_EVENT_CTRL = 8'h1C;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int EV_TX_EMPTY_BIT = 0;
	localparam int EV_RX_FULL_BIT = 1;
	localparam int EV_TX_IE_BIT = 2;
	localparam int EV_RX_IE_BIT = 3;
	localparam int BAUD_RX_IDLE_BIT = 6;
	localparam logic [7:0] REG8_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h00000000;

	// ------------------------------------------------------------
	// word lengths in shift clock edges
	// ------------------------------------------------------------
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;

	// receive status and control register layout
	typedef struct packed {
		logic serial_port_enable;
		logic nine_bit_receive_select;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic address_detect_enable;
		logic framing_error_flag;
		logic overrun_error_flag;
		logic received_ninth_bit;
	} ssp_rx_status_t;

	// transmit status and control register layout
	typedef struct packed {
		logic clock_source_select;
		logic nine_bit_transmit_select;
		logic transmit_enable;
		logic sync_mode_select;
		logic send_break;
		logic high_baud_select;
		logic shift_register_empty;
		logic transmit_ninth_bit;
	} ssp_tx_status_t;

	// transmit shifter states
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} ssp_tx_state_t;

endpackage

// ### tb/ssp_master_model.sv
// behavioural synchronous master that drives the shift clock and the data line of the port
`timescale 1ns/1ns
`default_nettype none

module ssp_master_model
(
	// link pins
	output logic shift_clock,
	output logic data_drive,
	input wire logic data_wire
);
	// ------------------------------------------------------------
	// idle state
	// ------------------------------------------------------------
	// clock idles low between frames; a free-running clock would hide edge miscounts
	initial
	begin
		shift_clock = 1'b0;
		data_drive = 1'b0;
	end

	// ------------------------------------------------------------
	// one frame, lsb first, 125 ns per bit
	// ------------------------------------------------------------
	// data changes with the rising edge and is taken at the falling edge; nonblocking updates
	// keep the pins race free when a link edge lands on a system clock edge
	task automatic frame(input int n, input logic [8:0] send, input bit drive, output logic [8:0] got);
		got = 9'h000;
		for (int i = 0; i < n; i++)
		begin
			shift_clock <= 1'b1;
			data_drive <= drive ? send[i] : ~data_drive; // undriven line keeps changing
			#63;
			shift_clock <= 1'b0;
			got[i] = data_wire;
			#31;
			// released line shows the inverse of its last level, well clear of the last edge
			if (i == n - 1)
				data_drive <= ~data_drive;
			#31;
		end
	endtask
endmodule

`default_nettype wire

// ### tb/tb_ssp_top.sv
// self-checking testbench of the synchronous slave serial port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g))

module tb_ssp_top;
	import ssp_pkg::*;

	// ------------------------------------------------------------
	// signals and bench model state
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclk;
	logic mdata;
	logic dout;
	logic doe;
	logic wake;
	wire sdata_wire = doe ? dout : mdata;
	logic [31:0] rdv;
	logic errv;
	logic [8:0] cap;
	logic [8:0] word_q[$];
	logic [7:0] rx_a;
	logic [7:0] rx_b;
	int fails = 0;
	int samples_checked = 0;
	localparam logic [7:0] OFS_LIST [8] = '{OFS_RX_STATUS, OFS_TX_HOLD, OFS_TX_STATUS, OFS_BAUD_CTRL,
		OFS_BAUD_DIV_HI, OFS_BAUD_DIV_LO, OFS_RX_BUF, OFS_EVENT_CTRL};
	localparam logic [7:0] RST_EXP [8] = '{8'h00, 8'h00, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h01};
	localparam logic [7:0] REF_TX [4] = '{8'h90, 8'h20, 8'h30, 8'h30};
	localparam logic [7:0] REF_RX [4] = '{8'h90, 8'h90, 8'hA0, 8'h10};

	// 125 MHz system clock
	always #4 pclk = ~pclk;

	ssp_top ssp_top_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.shift_clock_pin_in(sclk),
		.serial_data_pin_in(sdata_wire),
		.serial_data_pin_out(dout),
		.serial_data_pin_oe(doe),
		.wake_request(wake)
	);

	ssp_master_model ssp_master_model_inst (
		.shift_clock(sclk),
		.data_drive(mdata),
		.data_wire(sdata_wire)
	);

	// ------------------------------------------------------------
	// compare, verdict and bus tasks
	// ------------------------------------------------------------
	task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic give_verdict();
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// apb transfer; the answer is taken only at the edge where pready is sampled high
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait count is assumed here; a slave that never answers runs into the watchdog
		while (pready !== 1'b1)
			@(posedge pclk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask

	// frames end at a falling edge; flags need a few cycles of synchroniser latency
	task automatic settle();
		repeat (10) @(posedge pclk);
	endtask

	// a hang is cut short well after the expected run of about 13 us
	initial
	begin
		#200000;
		fails++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(4));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, with shifter empty and receiver idle both reading one
		for (int i = 0; i < 8; i++)
		begin
			rd(OFS_LIST[i]);
			`CHK("reset value", RST_EXP[i], rdv);
		end
		// divisor registers are plain storage in slave mode; unmapped place is refused
		for (int i = 0; i < 2; i++)
		begin
			rx_a = 8'($urandom);
			wr(i == 0 ? OFS_BAUD_DIV_HI : OFS_BAUD_DIV_LO, {24'h000000, rx_a});
			rd(i == 0 ? OFS_BAUD_DIV_HI : OFS_BAUD_DIV_LO);
			`CHK("divisor readback", rx_a, rdv);
		end
		wr(8'h20, 32'h000000FF);
		`CHK("unmapped write error", 1, errv);
		rd(8'h20);
		`CHK("unmapped read data", 0, rdv);
		// frames outside slave reception must not be taken
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_TX_STATUS, REF_TX[i]);
			wr(OFS_RX_STATUS, REF_RX[i]);
			ssp_master_model_inst.frame(8, 9'($urandom), 1'b1, cap);
			settle();
			rd(OFS_EVENT_CTRL);
			`CHK("rx full refused", 0, rdv[EV_RX_FULL_BIT]);
		end
		// holding write without transmit enable starts nothing
		wr(OFS_TX_STATUS, 8'h10);
		wr(OFS_RX_STATUS, 8'h80);
		wr(OFS_TX_HOLD, 32'h000000A5);
		rd(OFS_EVENT_CTRL);
		`CHK("tx empty kept", 1, rdv[EV_TX_EMPTY_BIT]);
		`CHK("data pin idle", 0, doe);
		// eight-bit reception with wake masked
		wr(OFS_EVENT_CTRL, 8'h00);
		wr(OFS_RX_STATUS, 8'h90);
		rx_a = 8'($urandom);
		ssp_master_model_inst.frame(8, {1'b0, rx_a}, 1'b1, cap);
		settle();
		rd(OFS_EVENT_CTRL);
		`CHK("rx full", 8'h03, rdv);
		`CHK("wake masked", 0, wake);
		rd(OFS_RX_STATUS);
		`CHK("rx status", 8'h90, rdv);
		rd(OFS_RX_BUF);
		`CHK("rx byte", rx_a, rdv);
		rd(OFS_EVENT_CTRL);
		`CHK("rx full cleared", 8'h01, rdv);
		// two words unread: the second overruns and is dropped
		wr(OFS_EVENT_CTRL, 8'h08);
		rx_a = 8'($urandom);
		rx_b = ~rx_a;
		ssp_master_model_inst.frame(8, {1'b0, rx_a}, 1'b1, cap);
		ssp_master_model_inst.frame(8, {1'b0, rx_b}, 1'b1, cap);
		settle();
		rd(OFS_EVENT_CTRL);
		`CHK("rx full again", 8'h0B, rdv);
		`CHK("rx wake", 1, wake);
		rd(OFS_RX_STATUS);
		`CHK("overrun set", 8'h92, rdv);
		wr(OFS_RX_STATUS, 8'h80);
		rd(OFS_RX_STATUS);
		`CHK("overrun cleared", 8'h80, rdv);
		rd(OFS_RX_BUF);
		`CHK("first word kept", rx_a, rdv);
		// nine-bit reception
		wr(OFS_RX_STATUS, 8'hD0);
		rx_a = 8'($urandom);
		ssp_master_model_inst.frame(9, {1'b1, rx_a}, 1'b1, cap);
		settle();
		rd(OFS_RX_STATUS);
		`CHK("ninth bit", 8'hD1, rdv);
		rd(OFS_RX_BUF);
		`CHK("nine bit low byte", rx_a, rdv);
		// two words written back to back, wake on empty
		wr(OFS_RX_STATUS, 8'h80);
		wr(OFS_TX_STATUS, 8'h30);
		wr(OFS_EVENT_CTRL, 8'h04);
		for (int i = 0; i < 2; i++)
		begin
			word_q.push_back(9'($urandom % 256));
			wr(OFS_TX_HOLD, 32'(word_q[i]));
		end
		rd(OFS_EVENT_CTRL);
		`CHK("tx empty clear", 8'h04, rdv);
		`CHK("no tx wake", 0, wake);
		`CHK("data pin driven", 1, doe);
		rd(OFS_TX_STATUS);
		`CHK("shifter busy", 8'h30, rdv);
		ssp_master_model_inst.frame(8, 9'h000, 1'b0, cap);
		`CHK("first word", word_q.pop_front(), {1'b0, cap[7:0]});
		settle();
		rd(OFS_EVENT_CTRL);
		`CHK("tx empty set", 8'h05, rdv);
		`CHK("tx wake", 1, wake);
		ssp_master_model_inst.frame(8, 9'h000, 1'b0, cap);
		`CHK("second word", word_q.pop_front(), {1'b0, cap[7:0]});
		settle();
		rd(OFS_TX_STATUS);
		`CHK("shifter empty", 8'h32, rdv);
		// nine-bit transmission
		wr(OFS_TX_STATUS, 8'h71);
		word_q.push_back({1'b1, 8'($urandom)});
		wr(OFS_TX_HOLD, 32'(word_q[0][7:0]));
		ssp_master_model_inst.frame(9, 9'h000, 1'b0, cap);
		`CHK("nine bit word", word_q.pop_front(), cap);
		settle();
		give_verdict();
	end
endmodule

`default_nettype wire
